// ### design/tai_cfg.svh
// Constants for the timer-access instruction unit: opcodes, offsets, fields
//
// Overview of operation
// - Prescaler read puts prescaler high nibble in B, low nibble in A.
// - Prescaler write loads B:A into prescaler counter and its reload together.
// - First-timer read returns its high nibble in B, low nibble in A.
// - First-timer write loads B:A into first counter and its reload.
// - First reload-only write loads B:A into the reload, counter untouched.
// - Second-timer read returns its high nibble in B, low nibble in A.
// - Second-timer write loads B:A into second counter and its reload.
// - Third-timer read returns its high nibble in B, low nibble in A.
// - Third-timer write loads B:A into third counter and its low reload.
// - Third high-reload write loads B:A into the third high reload only.
// - Copy instruction moves the third low reload into the third counter.
// - First skip, enable clear: flag set means skip next and clear flag.
// - Second skip, enable clear: flag set means skip next and clear flag.
// - Third skip, enable clear: flag set means skip next and clear flag.
// - First enable is bit 2 of control one; when set, skip is a no-op.
// - Second enable is bit 3 of control one; when set, skip is a no-op.
// - Third enable is bit 0 of control two; when set, skip is a no-op.
`ifndef TAI_CFG_SVH
`define TAI_CFG_SVH

`define TAI_OP_RD_PS    10'h275
`define TAI_OP_WR_PS    10'h235
`define TAI_OP_RD_T1    10'h270
`define TAI_OP_WR_T1    10'h230
`define TAI_OP_WR_R1    10'h23f
`define TAI_OP_RD_T2    10'h271
`define TAI_OP_WR_T2    10'h231
`define TAI_OP_RD_T3    10'h272
`define TAI_OP_WR_T3    10'h232
`define TAI_OP_WR_R3H   10'h23d
`define TAI_OP_CP_R3L   10'h234
`define TAI_OP_SKIP_T1  10'h280
`define TAI_OP_SKIP_T2  10'h281
`define TAI_OP_SKIP_T3  10'h282

`define TAI_OFF_IC1     12'h000
`define TAI_OFF_IC2     12'h004
`define TAI_OFF_STAT    12'h008
`define TAI_OFF_MASK    12'h00c
`define TAI_OFF_CNT     12'h010
`define TAI_OFF_RLD     12'h014
`define TAI_OFF_FLAG    12'h018

`define TAI_IEN1_BIT    2
`define TAI_IEN2_BIT    3
`define TAI_IEN3_BIT    0

`define TAI_NEV         5
`define TAI_EV_SKIP     3
`define TAI_EV_RUN      4

`define TAI_RST_NIB     4'h0
`define TAI_RST_BYTE    8'hff

`endif

// ### design/tai_pkg.sv
// Types shared by the timer-access instruction unit
package tai_pkg;

    typedef enum logic [3:0] {
        TAI_NONE   = 4'h0,
        TAI_RD_PS  = 4'h1,
        TAI_WR_PS  = 4'h2,
        TAI_RD_T1  = 4'h3,
        TAI_WR_T1  = 4'h4,
        TAI_WR_R1  = 4'h5,
        TAI_RD_T2  = 4'h6,
        TAI_WR_T2  = 4'h7,
        TAI_RD_T3  = 4'h8,
        TAI_WR_T3  = 4'h9,
        TAI_WR_R3H = 4'ha,
        TAI_CP_R3L = 4'hb,
        TAI_SK_T1  = 4'hc,
        TAI_SK_T2  = 4'hd,
        TAI_SK_T3  = 4'he
    } tai_op_e;

    typedef struct packed {
        logic [3:0] b;
        logic [3:0] a;
    } tai_acc_s;

    typedef logic [7:0] tai_byte_t;

endpackage

// ### design/tai_core.sv
// Timer-access instruction unit with its timers and an AXI4-Lite register port
`timescale 1ns/10ps
`include "tai_cfg.svh"

module tai_core
    import tai_pkg::*;
#(
    parameter int TW = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        instr_valid,
    input  wire logic [9:0]  instr,
    input  wire tai_acc_s    acc_in,
    input  wire logic        ps_tick,
    input  wire logic [2:0]  tmr_tick,
    output logic             acc_load,
    output tai_acc_s         acc_out,
    output logic             skip_next,
    output logic             irq,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Nibble transfers through B:A only make sense for byte-wide timers
    if (TW != 8) begin : g_bad_width
        $error("tai_core: TW must be 8");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic tai_op_e tai_decode(input logic [9:0] w);
        tai_op_e r;
        r = TAI_NONE;
        case (w)
            `TAI_OP_RD_PS:   r = TAI_RD_PS;
            `TAI_OP_WR_PS:   r = TAI_WR_PS;
            `TAI_OP_RD_T1:   r = TAI_RD_T1;
            `TAI_OP_WR_T1:   r = TAI_WR_T1;
            `TAI_OP_WR_R1:   r = TAI_WR_R1;
            `TAI_OP_RD_T2:   r = TAI_RD_T2;
            `TAI_OP_WR_T2:   r = TAI_WR_T2;
            `TAI_OP_RD_T3:   r = TAI_RD_T3;
            `TAI_OP_WR_T3:   r = TAI_WR_T3;
            `TAI_OP_WR_R3H:  r = TAI_WR_R3H;
            `TAI_OP_CP_R3L:  r = TAI_CP_R3L;
            `TAI_OP_SKIP_T1: r = TAI_SK_T1;
            `TAI_OP_SKIP_T2: r = TAI_SK_T2;
            `TAI_OP_SKIP_T3: r = TAI_SK_T3;
            default:         r = TAI_NONE;
        endcase
        return r;
    endfunction

    tai_op_e     op;
    logic        skip_pend_reg;
    logic        exec;
    logic [3:0]  ic1_reg;
    logic [3:0]  ic2_reg;
    logic [2:0]  ien;
    logic [2:0]  req_flag_reg;
    logic [2:0]  skip_hit;
    logic [2:0]  wr_cnt;
    logic [2:0]  wr_rld;
    tai_byte_t   ps_cnt_reg;
    tai_byte_t   ps_rld_reg;
    tai_byte_t   tmr_cnt_reg [3];
    tai_byte_t   tmr_rld_reg [3];
    tai_byte_t   t3_high_rld_reg;
    logic [2:0]  tmr_uf;

    assign op   = tai_decode(instr);
    assign exec = instr_valid && !skip_pend_reg;
    assign ien  = {ic2_reg[`TAI_IEN3_BIT], ic1_reg[`TAI_IEN2_BIT],
                   ic1_reg[`TAI_IEN1_BIT]};

    always_comb begin
        skip_hit = 3'h0;
        wr_cnt   = 3'h0;
        wr_rld   = 3'h0;
        if (exec) begin
            skip_hit[0] = op == TAI_SK_T1 && !ien[0] && req_flag_reg[0];
            skip_hit[1] = op == TAI_SK_T2 && !ien[1] && req_flag_reg[1];
            skip_hit[2] = op == TAI_SK_T3 && !ien[2] && req_flag_reg[2];
            wr_cnt[0]   = op == TAI_WR_T1;
            wr_rld[0]   = op == TAI_WR_T1 || op == TAI_WR_R1;
            wr_cnt[1]   = op == TAI_WR_T2;
            wr_rld[1]   = op == TAI_WR_T2;
            wr_cnt[2]   = op == TAI_WR_T3;
            wr_rld[2]   = op == TAI_WR_T3;
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_cnt_reg <= `TAI_RST_BYTE;
            ps_rld_reg <= `TAI_RST_BYTE;
        end else if (exec && op == TAI_WR_PS) begin
            ps_cnt_reg <= acc_in;
            ps_rld_reg <= acc_in;
        end else if (ps_tick) begin
            ps_cnt_reg <= (ps_cnt_reg == 8'h00) ? ps_rld_reg : ps_cnt_reg - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Timers: an instruction write wins over a count in the same cycle
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_tmr
        assign tmr_uf[i] = tmr_tick[i] && tmr_cnt_reg[i] == 8'h00 && !wr_cnt[i];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tmr_cnt_reg[i] <= `TAI_RST_BYTE;
            end else if (wr_cnt[i]) begin
                tmr_cnt_reg[i] <= acc_in;
            end else if (i == 2 && exec && op == TAI_CP_R3L) begin
                tmr_cnt_reg[i] <= tmr_rld_reg[i];
            end else if (tmr_tick[i]) begin
                tmr_cnt_reg[i] <= tmr_uf[i] ? tmr_rld_reg[i] : tmr_cnt_reg[i] - 8'h01;
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tmr_rld_reg[i] <= `TAI_RST_BYTE;
            end else if (wr_rld[i]) begin
                tmr_rld_reg[i] <= acc_in;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t3_high_rld_reg <= `TAI_RST_BYTE;
        end else if (exec && op == TAI_WR_R3H) begin
            t3_high_rld_reg <= acc_in;
        end
    end

    // Underflow sets win over a skip-instruction clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_flag_reg <= 3'h0;
        end else begin
            req_flag_reg <= (req_flag_reg & ~skip_hit) | tmr_uf;
        end
    end

    // ------------------------------------------------------------
    // Accumulator return and skip
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_load <= 1'b0;
            acc_out  <= '{b: `TAI_RST_NIB, a: `TAI_RST_NIB};
        end else begin
            acc_load <= exec && (op == TAI_RD_PS || op == TAI_RD_T1 ||
                                 op == TAI_RD_T2 || op == TAI_RD_T3);
            // A dropped or idle word must not disturb the held result
            case (exec ? op : TAI_NONE)
                TAI_RD_PS: acc_out <= ps_cnt_reg;
                TAI_RD_T1: acc_out <= tmr_cnt_reg[0];
                TAI_RD_T2: acc_out <= tmr_cnt_reg[1];
                TAI_RD_T3: acc_out <= tmr_cnt_reg[2];
                default:   acc_out <= acc_out;
            endcase
        end
    end

    // The word after a taken skip is still presented, then dropped here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_pend_reg <= 1'b0;
            skip_next     <= 1'b0;
        end else begin
            skip_next <= |skip_hit;
            if (|skip_hit) begin
                skip_pend_reg <= 1'b1;
            end else if (instr_valid) begin
                skip_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave and interrupt status
    // ------------------------------------------------------------
    logic                aw_got_reg;
    logic                w_got_reg;
    logic [11:0]         awaddr_reg;
    logic [31:0]         wdata_reg;
    logic                wstrb0_reg;
    logic                wr_fire;
    logic [`TAI_NEV-1:0] stat_reg;
    logic [`TAI_NEV-1:0] mask_reg;
    logic [`TAI_NEV-1:0] ev;

    function automatic logic tai_mapped(input logic [11:0] ad);
        return ad == `TAI_OFF_IC1  || ad == `TAI_OFF_IC2 || ad == `TAI_OFF_STAT ||
               ad == `TAI_OFF_MASK || ad == `TAI_OFF_CNT || ad == `TAI_OFF_RLD ||
               ad == `TAI_OFF_FLAG;
    endfunction

    assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign ev            = {exec && op != TAI_NONE, |skip_hit, tmr_uf};
    assign irq           = |(stat_reg & mask_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg  <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
            end else if (wr_fire) begin
                aw_got_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg  <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= tai_mapped(awaddr_reg) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ic1_reg  <= `TAI_RST_NIB;
            ic2_reg  <= `TAI_RST_NIB;
            mask_reg <= '0;
        end else if (wr_fire && wstrb0_reg) begin
            if (awaddr_reg == `TAI_OFF_IC1) begin
                ic1_reg <= wdata_reg[3:0];
            end
            if (awaddr_reg == `TAI_OFF_IC2) begin
                ic2_reg <= wdata_reg[3:0];
            end
            if (awaddr_reg == `TAI_OFF_MASK) begin
                mask_reg <= wdata_reg[`TAI_NEV-1:0];
            end
        end
    end

    // Write one to clear; a new event in the same cycle keeps its bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= '0;
        end else if (wr_fire && wstrb0_reg && awaddr_reg == `TAI_OFF_STAT) begin
            stat_reg <= (stat_reg & ~wdata_reg[`TAI_NEV-1:0]) | ev;
        end else begin
            stat_reg <= stat_reg | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tai_mapped({s_axi_araddr[11:2], 2'b00}) ? 2'b00 : 2'b10;
            case ({s_axi_araddr[11:2], 2'b00})
                `TAI_OFF_IC1:  s_axi_rdata <= {28'h0, ic1_reg};
                `TAI_OFF_IC2:  s_axi_rdata <= {28'h0, ic2_reg};
                `TAI_OFF_STAT: s_axi_rdata <= {27'h0, stat_reg};
                `TAI_OFF_MASK: s_axi_rdata <= {27'h0, mask_reg};
                `TAI_OFF_CNT:  s_axi_rdata <= {tmr_cnt_reg[2], tmr_cnt_reg[1],
                                               tmr_cnt_reg[0], ps_cnt_reg};
                `TAI_OFF_RLD:  s_axi_rdata <= {t3_high_rld_reg, tmr_rld_reg[2],
                                               tmr_rld_reg[0], ps_rld_reg};
                `TAI_OFF_FLAG: s_axi_rdata <= {28'h0, skip_pend_reg, req_flag_reg};
                default:       s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_do(tai_op_e o);
        exec && op == o;
    endsequence

    property p_rd_ps;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_RD_PS) |=> acc_load && acc_out == $past(ps_cnt_reg);
    endproperty
    a_rd_ps: assert property (p_rd_ps) else $error("prescaler read wrong");

    property p_wr_ps;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_WR_PS) |=> ps_cnt_reg == $past(acc_in) && ps_rld_reg == $past(acc_in);
    endproperty
    a_wr_ps: assert property (p_wr_ps) else $error("prescaler write wrong");

    property p_rd_t2;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_RD_T2) |=> acc_load && acc_out.b == $past(tmr_cnt_reg[1][7:4])
                            && acc_out.a == $past(tmr_cnt_reg[1][3:0]);
    endproperty
    a_rd_t2: assert property (p_rd_t2) else $error("second timer read wrong");

    property p_wr_t1;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_WR_T1) |=> tmr_cnt_reg[0] == $past(acc_in)
                            && tmr_rld_reg[0] == $past(acc_in);
    endproperty
    a_wr_t1: assert property (p_wr_t1) else $error("first timer write wrong");

    property p_wr_r1;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_WR_R1) ##0 !tmr_tick[0] |=> tmr_rld_reg[0] == $past(acc_in)
                                             && $stable(tmr_cnt_reg[0]);
    endproperty
    a_wr_r1: assert property (p_wr_r1) else $error("reload-only write wrong");

    property p_wr_r3h;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_WR_R3H) ##0 !tmr_tick[2] |=> t3_high_rld_reg == $past(acc_in)
                                              && $stable(tmr_cnt_reg[2]);
    endproperty
    a_wr_r3h: assert property (p_wr_r3h) else $error("high reload write wrong");

    property p_cp_r3l;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_CP_R3L) |=> tmr_cnt_reg[2] == $past(tmr_rld_reg[2]);
    endproperty
    a_cp_r3l: assert property (p_cp_r3l) else $error("low reload copy wrong");

    sequence s_skip_taken;
        s_do(TAI_SK_T1) ##0 !ic1_reg[`TAI_IEN1_BIT] && req_flag_reg[0] && !tmr_uf[0];
    endsequence

    property p_skip_t1;
        @(posedge aclk) disable iff (!aresetn)
        s_skip_taken |=> skip_next && !req_flag_reg[0] && skip_pend_reg;
    endproperty
    a_skip_t1: assert property (p_skip_t1) else $error("first skip wrong");

    property p_nop_t3;
        @(posedge aclk) disable iff (!aresetn)
        s_do(TAI_SK_T3) ##0 ic2_reg[`TAI_IEN3_BIT] && !tmr_uf[2]
            |=> !skip_next && $stable(req_flag_reg[2]);
    endproperty
    a_nop_t3: assert property (p_nop_t3) else $error("third skip not a no-op");

    property p_skipped;
        @(posedge aclk) disable iff (!aresetn)
        skip_pend_reg && instr_valid && !(|tmr_tick) && !ps_tick
            |=> !acc_load && !skip_next && $stable(ps_cnt_reg) && $stable(req_flag_reg)
                && $stable(t3_high_rld_reg);
    endproperty
    a_skipped: assert property (p_skipped) else $error("skipped word took effect");

endmodule

// ### dv/tai_cpu_model.sv
// CPU fetch and execute partner that issues group words and keeps B:A
`timescale 1ns/10ps

module tai_cpu_model
    import tai_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       issue,
    input  wire logic [9:0] word,
    input  wire tai_acc_s   acc,
    input  wire logic       acc_load,
    input  wire tai_acc_s   acc_out,
    output logic            instr_valid,
    output logic [9:0]      instr,
    output tai_acc_s        acc_in,
    output tai_acc_s        ba_reg
);
    // Payload flips between words so sampling it off-valid shows up
    always_ff @(posedge aclk) begin
        instr_valid <= issue & aresetn;
        if (!aresetn) begin
            instr  <= 10'h155;
            acc_in <= 8'h5a;
        end else if (issue) begin
            instr  <= word;
            acc_in <= acc;
        end else begin
            instr  <= ~instr;
            acc_in <= ~acc_in;
        end
    end
    // The pair takes a read result one cycle later, ready for the next word
    always_ff @(posedge aclk) begin
        if (!aresetn) ba_reg <= 8'h00;
        else if (acc_load) ba_reg <= acc_out;
    end
endmodule

// ### dv/tai_core_test.sv
// Self-checking bench for the timer-access instruction unit
`timescale 1ns/10ps
`include "tai_cfg.svh"

module tai_core_test
    import tai_pkg::*;
;
    logic        aclk, aresetn, issue, ps_tick, instr_valid, acc_load, skip_next, irq;
    logic [2:0]  tmr_tick;
    logic [9:0]  word, instr, wop;
    tai_acc_s    acc, acc_in, acc_out, ba_reg;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, rsp;
    logic [7:0]  cnt [4];
    logic [7:0]  rl [4];
    logic [7:0]  r3h, v;
    logic [3:0]  flg;
    logic [9:0]  wr_ops [6] = '{`TAI_OP_WR_PS, `TAI_OP_WR_T1, `TAI_OP_WR_R1,
                                `TAI_OP_WR_T2, `TAI_OP_WR_T3, `TAI_OP_WR_R3H};
    logic [9:0]  rd_ops [4] = '{`TAI_OP_RD_PS, `TAI_OP_RD_T1, `TAI_OP_RD_T2, `TAI_OP_RD_T3};
    integer      seed = 32'hff229fbe;
    int          err_count = 0;
    int          checks_done = 0;
    bit          e, sk;

    tai_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .issue(issue), .word(word), .acc(acc),
        .acc_load(acc_load), .acc_out(acc_out), .instr_valid(instr_valid), .instr(instr),
        .acc_in(acc_in), .ba_reg(ba_reg));

    tai_core dut (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr(instr),
        .acc_in(acc_in), .ps_tick(ps_tick), .tmr_tick(tmr_tick), .acc_load(acc_load),
        .acc_out(acc_out), .skip_next(skip_next), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Checking and expectation helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic void ref_wr(input logic [9:0] op, input logic [7:0] d);
        case (op)
            `TAI_OP_WR_PS: begin
                cnt[0] = d;
                rl[0] = d;
            end
            `TAI_OP_WR_T1: begin
                cnt[1] = d;
                rl[1] = d;
            end
            `TAI_OP_WR_R1: rl[1] = d;
            `TAI_OP_WR_T2: begin
                cnt[2] = d;
                rl[2] = d;
            end
            `TAI_OP_WR_T3: begin
                cnt[3] = d;
                rl[3] = d;
            end
            default: r3h = d;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic exec(input logic [9:0] op, input logic [7:0] d);
        @(posedge aclk);
        issue <= 1'b1;
        word <= op;
        acc <= d;
        @(posedge aclk);
        issue <= 1'b0;
        @(posedge aclk);
        #1;
    endtask

    task automatic rd_chk(input int i);
        exec(rd_ops[i], 8'h00);
        chk({acc_load, skip_next, acc_out}, {2'b10, cnt[i]});
        @(posedge aclk);
        #1;
        chk(ba_reg, cnt[i]);
    endtask

    task automatic tick(input int i, input int n);
        repeat (n) begin
            @(posedge aclk);
            tmr_tick[i-1] <= 1'b1;
            @(posedge aclk);
            tmr_tick[i-1] <= 1'b0;
            if (cnt[i] == 8'h00) begin
                cnt[i] = rl[i];
                flg[i] = 1'b1;
            end else begin
                cnt[i] = cnt[i] - 8'h01;
            end
        end
    endtask

    task automatic axw(input logic [11:0] ad, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= ad;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'b0;
        #1;
    endtask

    task automatic axr(input logic [11:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic axc(input logic [11:0] ad, input logic [31:0] exp);
        axr(ad);
        chk({rsp, rd}, {2'b00, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {issue, ps_tick, tmr_tick, word, acc} = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        aresetn = 1'b0;
        cnt = '{default: 8'hff};
        rl = '{default: 8'hff};
        r3h = 8'hff;
        flg = 4'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axc(`TAI_OFF_IC1, 32'h0);
        axc(`TAI_OFF_STAT, 32'h0);
        axc(`TAI_OFF_CNT, 32'hffffffff);
        axc(`TAI_OFF_RLD, 32'hffffffff);
        axr(12'h100);
        chk({rsp, rd}, {2'b10, 32'h0});
        axw(12'h100, 32'h1);
        chk(rsp, 2'b10);
        // Random group writes; counters read back through both paths, reloads except timer two's over AXI only
        repeat (12) begin
            v = 8'($random(seed));
            wop = wr_ops[$unsigned($random(seed)) % 6];
            exec(wop, v);
            ref_wr(wop, v);
            chk({acc_load, skip_next}, 2'b00);
            for (int i = 0; i < 4; i++) rd_chk(i);
            axc(`TAI_OFF_CNT, {cnt[3], cnt[2], cnt[1], cnt[0]});
            axc(`TAI_OFF_RLD, {r3h, rl[3], rl[1], rl[0]});
        end
        exec(`TAI_OP_WR_T3, 8'h5a);
        ref_wr(`TAI_OP_WR_T3, 8'h5a);
        tick(3, 3);
        rd_chk(3);
        exec(`TAI_OP_CP_R3L, 8'h00);
        cnt[3] = rl[3];
        rd_chk(3);
        // Skip with flag clear, skip taken, skip with enable set
        for (int i = 1; i < 4; i++) begin
            foreach (wr_ops[m]) begin
                if (m > 2) continue;
                e = (m == 2);
                axw(`TAI_OFF_IC1, 32'(e && i == 1) << `TAI_IEN1_BIT | 32'(e && i == 2) << `TAI_IEN2_BIT);
                axw(`TAI_OFF_IC2, 32'(e && i == 3) << `TAI_IEN3_BIT);
                if (m != 0) begin
                    exec(`TAI_OP_WR_T1 + i - 1, 8'h00);
                    ref_wr(`TAI_OP_WR_T1 + i - 1, 8'h00);
                    tick(i, 1);
                end
                sk = !e && flg[i];
                exec(`TAI_OP_SKIP_T1 + i - 1, 8'h00);
                chk({acc_load, skip_next}, {1'b0, sk});
                if (sk) flg[i] = 1'b0;
                v = 8'($random(seed));
                exec(`TAI_OP_WR_R3H, v);
                if (!sk) r3h = v;
                axc(`TAI_OFF_RLD, {r3h, rl[3], rl[1], rl[0]});
                axc(`TAI_OFF_FLAG, {28'h0, 1'b0, flg[3:1]});
            end
        end
        // Interrupt raise, mask and clear
        axw(`TAI_OFF_STAT, 32'h1f);
        axw(`TAI_OFF_MASK, 32'h01);
        chk(irq, 1'b0);
        exec(`TAI_OP_WR_T1, 8'h00);
        ref_wr(`TAI_OP_WR_T1, 8'h00);
        tick(1, 1);
        axc(`TAI_OFF_STAT, 32'h11);
        chk(irq, 1'b1);
        axw(`TAI_OFF_MASK, 32'h00);
        chk(irq, 1'b0);
        axw(`TAI_OFF_MASK, 32'h01);
        axw(`TAI_OFF_STAT, 32'h01);
        chk(irq, 1'b0);
        axc(`TAI_OFF_STAT, 32'h10);
        end_of_test;
    end

    initial begin
        #1_000_000;
        err_count++;
        end_of_test;
    end
endmodule
